// ---- dtc_consts.svh ----
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DTC_OFF_MODE   8'h00
`define DTC_OFF_CTRL   8'h04
`define DTC_OFF_AUX    8'h08
`define DTC_OFF_CNT_A  8'h0C
`define DTC_OFF_CNT_B  8'h10
`define DTC_OFF_VEC    8'h14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DTC_MODE_RST   8'h00
`define DTC_CTRL_RST   8'h00
`define DTC_AUX_RST    8'h00
`define DTC_CNT_RST    16'h0000
`define DTC_AUX_MASK   8'hFC

// ----------------------------------------------------------------
// timer_ctrl_flags fields
// ----------------------------------------------------------------
`define DTC_CTRL_TF_B  7
`define DTC_CTRL_RUN_B 6
`define DTC_CTRL_TF_A  5
`define DTC_CTRL_RUN_A 4
`define DTC_CTRL_IE_B  3
`define DTC_CTRL_IT_B  2
`define DTC_CTRL_IE_A  1
`define DTC_CTRL_IT_A  0

// ----------------------------------------------------------------
// timer_mode_ctrl nibble, auxiliary_ctrl and vector-ack fields
// ----------------------------------------------------------------
`define DTC_TMODE_W    4
`define DTC_AUX_FAST_A 7
`define DTC_AUX_FAST_B 6
`define DTC_AUX_URM    5
`define DTC_AUX_ADC    4
`define DTC_AUX_SPI    3
`define DTC_AUX_LVF    2
`define DTC_VEC_EXT_A  0
`define DTC_VEC_TMR_A  1
`define DTC_VEC_EXT_B  2
`define DTC_VEC_TMR_B  3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DTC_SLOW_DIV   4'hC
`define DTC_PRE13_TOP  5'h1F

`endif

// ---- dtc_count_step.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_count_step
(
  input  wire dtc_pkg::dtc_mode_t mode,
  input  wire logic               split_owner,
  input  wire logic               inc_lo,
  input  wire logic               inc_hi,
  input  wire dtc_pkg::dtc_cnt_t  cnt,
  output dtc_pkg::dtc_cnt_t       next_cnt,
  output logic                    ovf_lo,
  output logic                    ovf_hi
);
  import dtc_pkg::*;

  always_comb
  begin
    next_cnt = cnt;
    ovf_lo   = 1'b0;
    ovf_hi   = 1'b0;
    case (mode)
      DTC_MODE_13:
      begin
        // upper three bits of the low byte take no part in the carry
        if (inc_lo)
        begin
          next_cnt.low_byte_count[4:0] = cnt.low_byte_count[4:0] + 5'h01;
          if (cnt.low_byte_count[4:0] == `DTC_PRE13_TOP)
          begin
            next_cnt.high_byte_reload = cnt.high_byte_reload + 8'h01;
            ovf_lo = (cnt.high_byte_reload == 8'hFF);
          end
        end
      end
      DTC_MODE_16:
      begin
        if (inc_lo)
        begin
          next_cnt = cnt + 16'h0001;
          ovf_lo   = (cnt == 16'hFFFF);
        end
      end
      DTC_MODE_RELOAD:
      begin
        if (inc_lo)
        begin
          if (cnt.low_byte_count == 8'hFF)
          begin
            next_cnt.low_byte_count = cnt.high_byte_reload;
            ovf_lo = 1'b1;
          end
          else
          begin
            next_cnt.low_byte_count = cnt.low_byte_count + 8'h01;
          end
        end
      end
      DTC_MODE_SPLIT:
      begin
        // the non-owner simply holds its count
        if (split_owner)
        begin
          if (inc_lo)
          begin
            next_cnt.low_byte_count = cnt.low_byte_count + 8'h01;
            ovf_lo = (cnt.low_byte_count == 8'hFF);
          end
          if (inc_hi)
          begin
            next_cnt.high_byte_reload = cnt.high_byte_reload + 8'h01;
            ovf_hi = (cnt.high_byte_reload == 8'hFF);
          end
        end
      end
      default:
      begin
        next_cnt = cnt;
      end
    endcase
  end

endmodule
`default_nettype wire

// ---- dtc_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// external event and interrupt pins
// ----------------------------------------------------------------
module dtc_pin_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] fall_req,
  input  wire logic [1:0] irq_lvl,
  output wire logic       timer_a_count_pin,
  output wire logic       timer_b_count_pin,
  output var  logic       ext_irq_a_pin,
  output var  logic       ext_irq_b_pin
);
  // count pins idle high; a request pulls a pin low for two clocks so the
  // sampler sees a one followed by a zero, never a glitch it could miss
  logic [1:0] low_a;
  logic [1:0] low_b;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_a <= 2'h0;
      low_b <= 2'h0;
      ext_irq_a_pin <= 1'b1;
      ext_irq_b_pin <= 1'b1;
    end
    else
    begin
      low_a <= fall_req[0] ? 2'h2 : low_a - 2'(low_a != 2'h0);
      low_b <= fall_req[1] ? 2'h2 : low_b - 2'(low_b != 2'h0);
      ext_irq_a_pin <= irq_lvl[0];
      ext_irq_b_pin <= irq_lvl[1];
    end
  end

  assign timer_a_count_pin = (low_a == 2'h0);
  assign timer_b_count_pin = (low_b == 2'h0);
endmodule

`default_nettype wire

// ---- dtc_pkg.sv ----
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_13     = 2'h0,
    DTC_MODE_16     = 2'h1,
    DTC_MODE_RELOAD = 2'h2,
    DTC_MODE_SPLIT  = 2'h3
  } dtc_mode_t;

  typedef struct packed {
    logic      gate;
    logic      counter_sel;
    dtc_mode_t mode;
  } dtc_tcfg_t;

  typedef struct packed {
    logic [7:0] high_byte_reload;
    logic [7:0] low_byte_count;
  } dtc_cnt_t;

endpackage

// ---- dtc_tick_div.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_tick_div
(
  input  wire logic pclk,
  input  wire logic presetn,
  output var  logic tick
);
  import dtc_pkg::*;

  logic [3:0] count;
  logic [3:0] next_count;
  logic       next_tick;

  always_comb
  begin
    next_count = (count == (`DTC_SLOW_DIV - 4'h1)) ? 4'h0 : count + 4'h1;
    next_tick  = (count == (`DTC_SLOW_DIV - 4'h1));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= 4'h0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

  default clocking dtc_div_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_tick_period: assert property (tick |-> ##12 tick)
    else $error("slow tick period is not twelve clocks");
  a_tick_single: assert property (tick |=> !tick [*8])
    else $error("slow tick repeated too soon");

endmodule
`default_nettype wire

// ---- dtc_top.sv ----
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_top
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic        timer_a_count_pin,
  input  wire logic        timer_b_count_pin,
  output logic             timer_a_overflow,
  output logic             timer_b_overflow,
  output logic             ext_irq_a_flag,
  output logic             ext_irq_b_flag,
  output logic             uart_sync_fast_baud,
  output logic             converter_irq_en,
  output logic             serial_periph_irq_en,
  output logic             low_volt_irq_en
);
  import dtc_pkg::*;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_word;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        wr_mode;
  logic        wr_ctrl;
  logic        wr_aux;
  logic        wr_vec;
  logic [1:0]  wr_cnt;

  logic [7:0]  timer_mode_ctrl;
  logic [7:0]  auxiliary_ctrl;
  logic [1:0]  run;
  logic [1:0]  irq_type;
  logic [7:0]  next_mode;
  logic [7:0]  next_aux;
  logic [1:0]  next_run;
  logic [1:0]  next_type;
  logic [7:0]  ctrl_rd;

  wire  [1:0]        tf_w;
  wire  [1:0]        ief_w;
  wire  [1:0][15:0]  cnt_w;
  wire  [1:0]        ovf_lo;
  wire  [1:0]        ovf_hi;

  assign setup  = psel & ~penable;
  // writes land only on the completing access edge
  assign wr_en  = psel & penable & pready & pwrite;
  assign wr_mode   = wr_en & (paddr == `DTC_OFF_MODE);
  assign wr_ctrl   = wr_en & (paddr == `DTC_OFF_CTRL);
  assign wr_aux    = wr_en & (paddr == `DTC_OFF_AUX);
  assign wr_vec    = wr_en & (paddr == `DTC_OFF_VEC);
  assign wr_cnt[0] = wr_en & (paddr == `DTC_OFF_CNT_A);
  assign wr_cnt[1] = wr_en & (paddr == `DTC_OFF_CNT_B);

  assign ctrl_rd = {tf_w[1], run[1], tf_w[0], run[0],
                    ief_w[1], irq_type[1], ief_w[0], irq_type[0]};

  always_comb
  begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      `DTC_OFF_MODE:  rd_word = {24'h00_0000, timer_mode_ctrl};
      `DTC_OFF_CTRL:  rd_word = {24'h00_0000, ctrl_rd};
      `DTC_OFF_AUX:   rd_word = {24'h00_0000, auxiliary_ctrl};
      `DTC_OFF_CNT_A: rd_word = {16'h0000, cnt_w[0]};
      `DTC_OFF_CNT_B: rd_word = {16'h0000, cnt_w[1]};
      `DTC_OFF_VEC:   rd_word = 32'h0000_0000;
      default:        hit = 1'b0;
    endcase
    // answer is prepared in setup so pready and prdata leave flops
    next_pready  = setup;
    next_prdata  = (setup & ~pwrite) ? rd_word : 32'h0000_0000;
    next_pslverr = setup & ~hit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb
  begin
    next_mode = wr_mode ? pwdata[7:0] : timer_mode_ctrl;
    next_aux  = wr_aux ? (pwdata[7:0] & `DTC_AUX_MASK) : auxiliary_ctrl;
    next_run  = run;
    next_type = irq_type;
    if (wr_ctrl)
    begin
      next_run  = {pwdata[`DTC_CTRL_RUN_B], pwdata[`DTC_CTRL_RUN_A]};
      next_type = {pwdata[`DTC_CTRL_IT_B], pwdata[`DTC_CTRL_IT_A]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_mode_ctrl <= `DTC_MODE_RST;
      auxiliary_ctrl  <= `DTC_AUX_RST;
      run             <= 2'h0;
      irq_type        <= 2'h0;
    end
    else
    begin
      timer_mode_ctrl <= next_mode;
      auxiliary_ctrl  <= next_aux;
      run             <= next_run;
      irq_type        <= next_type;
    end
  end

  // the uart and peripheral enables only leave the block as levels
  assign uart_sync_fast_baud  = auxiliary_ctrl[`DTC_AUX_URM];
  assign converter_irq_en     = auxiliary_ctrl[`DTC_AUX_ADC];
  assign serial_periph_irq_en = auxiliary_ctrl[`DTC_AUX_SPI];
  assign low_volt_irq_en      = auxiliary_ctrl[`DTC_AUX_LVF];

  // ----------------------------------------------------------------
  // pin sampling and clock selection
  // ----------------------------------------------------------------
  logic       slow_tick;
  logic [1:0] irq_pin;
  logic [1:0] cnt_pin;
  logic [1:0] irq_prev;
  logic [1:0] cnt_prev;
  logic       split_a;
  logic [1:0] fast;

  assign irq_pin = {ext_irq_b_pin, ext_irq_a_pin};
  assign cnt_pin = {timer_b_count_pin, timer_a_count_pin};
  assign fast    = {auxiliary_ctrl[`DTC_AUX_FAST_B], auxiliary_ctrl[`DTC_AUX_FAST_A]};
  assign split_a = (timer_mode_ctrl[1:0] == DTC_MODE_SPLIT);

  dtc_tick_div u_div
  (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (slow_tick)
  );

  // idle-high reset value makes a pin already low at start look like a falling edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_prev <= 2'h3;
      cnt_prev <= 2'h3;
    end
    else
    begin
      irq_prev <= irq_pin;
      cnt_prev <= cnt_pin;
    end
  end

  // ----------------------------------------------------------------
  // per-timer counting and flags
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : gen_ch
      localparam int TFP = (ch == 0) ? `DTC_CTRL_TF_A : `DTC_CTRL_TF_B;
      localparam int IEP = (ch == 0) ? `DTC_CTRL_IE_A : `DTC_CTRL_IE_B;
      localparam int VEP = (ch == 0) ? `DTC_VEC_EXT_A : `DTC_VEC_EXT_B;
      localparam int VTP = (ch == 0) ? `DTC_VEC_TMR_A : `DTC_VEC_TMR_B;

      dtc_tcfg_t cfg;
      dtc_cnt_t  cnt;
      dtc_cnt_t  core_next;
      dtc_cnt_t  next_cnt;
      logic      tick;
      logic      edge_seen;
      logic      irq_edge;
      logic      inc_lo;
      logic      tf_set;
      logic      tf;
      logic      ief;
      logic      next_tf;
      logic      next_ief;

      assign cfg       = timer_mode_ctrl[ch*`DTC_TMODE_W +: `DTC_TMODE_W];
      assign tick      = fast[ch] | slow_tick;
      assign edge_seen = cnt_prev[ch] & ~cnt_pin[ch];
      assign irq_edge  = irq_prev[ch] & ~irq_pin[ch];
      assign inc_lo    = run[ch] & (~cfg.gate | irq_pin[ch])
                         & (cfg.counter_sel ? edge_seen : tick);

      dtc_count_step u_step
      (
        .mode        (cfg.mode),
        .split_owner (ch == 0),
        .inc_lo      (inc_lo),
        .inc_hi      (run[1] & gen_ch[0].tick),
        .cnt         (cnt),
        .next_cnt    (core_next),
        .ovf_lo      (ovf_lo[ch]),
        .ovf_hi      (ovf_hi[ch])
      );

      // in split mode timer B's own rollover no longer reaches its flag
      if (ch == 0)
      begin : gen_set_a
        assign tf_set = ovf_lo[0];
      end
      else
      begin : gen_set_b
        assign tf_set = split_a ? ovf_hi[0] : ovf_lo[1];
      end

      always_comb
      begin
        next_cnt = wr_cnt[ch] ? dtc_cnt_t'(pwdata[15:0]) : core_next;
        next_tf  = wr_ctrl ? pwdata[TFP] : (wr_vec & pwdata[VTP]) ? 1'b0 : tf;
        next_tf  = next_tf | tf_set;
        if (!irq_type[ch])
        begin
          next_ief = ~irq_pin[ch];
        end
        else
        begin
          next_ief = wr_ctrl ? pwdata[IEP] : (wr_vec & pwdata[VEP]) ? 1'b0 : ief;
          next_ief = next_ief | irq_edge;
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cnt <= `DTC_CNT_RST;
          tf  <= 1'b0;
          ief <= 1'b0;
        end
        else
        begin
          cnt <= next_cnt;
          tf  <= next_tf;
          ief <= next_ief;
        end
      end

      assign cnt_w[ch] = cnt;
      assign tf_w[ch]  = tf;
      assign ief_w[ch] = ief;
    end
  endgenerate

  assign timer_a_overflow = tf_w[0];
  assign timer_b_overflow = tf_w[1];
  assign ext_irq_a_flag   = ief_w[0];
  assign ext_irq_b_flag   = ief_w[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dtc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_apb_answer: assert property (setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  a_apb_unmapped: assert property (setup && !hit |=> pslverr && pready)
    else $error("unmapped address not flagged");
  a_mode_store: assert property (wr_mode |=> timer_mode_ctrl == $past(pwdata[7:0]))
    else $error("mode register did not take write");
  a_stop_holds: assert property (!run[0] && !split_a && !wr_cnt[0]
                                 |=> $stable(cnt_w[0]))
    else $error("timer A moved while stopped");
  a_gate_blocks: assert property (run[0] && gen_ch[0].cfg.gate && !irq_pin[0]
                                  && !split_a && !wr_cnt[0] |=> $stable(cnt_w[0]))
    else $error("gated timer A counted with pin low");
  a_reload_copy: assert property (gen_ch[0].cfg.mode == DTC_MODE_RELOAD && ovf_lo[0]
                                  && !wr_cnt[0]
                                  |=> cnt_w[0][7:0] == $past(cnt_w[0][15:8]))
    else $error("reload did not copy high byte");
  a_ovf_flag: assert property (ovf_lo[0] |=> timer_a_overflow)
    else $error("timer A overflow flag not set");
  a_split_flag: assert property (split_a && ovf_hi[0] |=> timer_b_overflow)
    else $error("split high byte did not set timer B flag");
  a_level_follow: assert property (!irq_type[0] ##1 !irq_type[0]
                                   |-> ext_irq_a_flag == !$past(ext_irq_a_pin))
    else $error("level flag not following pin");
  a_vec_clear: assert property (wr_vec && pwdata[`DTC_VEC_TMR_A] && !ovf_lo[0]
                                |=> !timer_a_overflow)
    else $error("vector ack did not clear timer A flag");
  a_edge_count: assert property (run[0] && gen_ch[0].cfg.counter_sel && !gen_ch[0].cfg.gate
                                 && gen_ch[0].cfg.mode == DTC_MODE_16 && !wr_cnt[0]
                                 && !gen_ch[0].edge_seen |=> $stable(cnt_w[0]))
    else $error("counter moved without an input edge");

  c_reload_ovf: cover property (gen_ch[0].cfg.mode == DTC_MODE_RELOAD && ovf_lo[0]);
  c_split_ovf:  cover property (split_a && ovf_hi[0]);
  c_ext_edge:   cover property (irq_type[1] && gen_ch[1].irq_edge ##1 ext_irq_b_flag);
  c_bus_error:  cover property (pslverr);

endmodule
`default_nettype wire

// ---- dual_timer_counter_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module dual_timer_counter_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  fall_req;
  logic [1:0]  irq_lvl;
  logic        ext_irq_a_pin;
  logic        ext_irq_b_pin;
  wire         timer_a_count_pin;
  wire         timer_b_count_pin;
  logic        timer_a_overflow;
  logic        timer_b_overflow;
  logic        ext_irq_a_flag;
  logic        ext_irq_b_flag;
  logic [3:0]  aux_out;
  logic [31:0] rdv;
  logic [31:0] v1;
  logic        rerr;
  int          cyc;
  int          smp_cyc;
  int          mismatches;
  int          cmp_count;
  int          n;

  dtc_top dtc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_a_pin(ext_irq_a_pin), .ext_irq_b_pin(ext_irq_b_pin),
    .timer_a_count_pin(timer_a_count_pin), .timer_b_count_pin(timer_b_count_pin),
    .timer_a_overflow(timer_a_overflow), .timer_b_overflow(timer_b_overflow),
    .ext_irq_a_flag(ext_irq_a_flag), .ext_irq_b_flag(ext_irq_b_flag),
    .uart_sync_fast_baud(aux_out[3]), .converter_irq_en(aux_out[2]),
    .serial_periph_irq_en(aux_out[1]), .low_volt_irq_en(aux_out[0]));

  dtc_pin_model dtc_pin_model_i (.pclk(pclk), .presetn(presetn), .fall_req(fall_req),
    .irq_lvl(irq_lvl), .timer_a_count_pin(timer_a_count_pin),
    .timer_b_count_pin(timer_b_count_pin), .ext_irq_a_pin(ext_irq_a_pin),
    .ext_irq_b_pin(ext_irq_b_pin));

  always #20 pclk = ~pclk;

  always @(posedge pclk)
    cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // bus, compare and model helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // a wait past the bound counts as a mismatch rather than hanging
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 16)
    begin
      @(posedge pclk);
      k++;
    end
    if (k == 16)
      mismatches++;
    rdv     = prdata;
    rerr    = pslverr;
    smp_cyc = cyc;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [16:0] step(input logic [1:0] m, input logic [15:0] c);
    logic [7:0] hi;
    hi = c[15:8] + 8'h01;
    case (m)
      2'h0: return (c[4:0] == 5'h1F) ? {&c[15:8], hi, c[7:5], 5'h00}
                                     : {1'b0, c[15:5], c[4:0] + 5'h01};
      2'h2: return (c[7:0] == 8'hFF) ? {1'b1, c[15:8], c[15:8]} : {1'b0, c + 16'h0001};
      default: return {1'b0, c} + 17'h1;
    endcase
  endfunction

  task automatic arm(input logic t, input logic [3:0] nib, input logic [15:0] c);
    apb(1'b1, 8'h00, t ? 32'({nib, 4'h0}) : 32'(nib));
    apb(1'b1, 8'h04, 32'h0000);
    apb(1'b1, t ? 8'h10 : 8'h0C, 32'(c));
    apb(1'b1, 8'h04, t ? 32'h0040 : 32'h0010);
  endtask

  task automatic pulse(input logic t);
    fall_req <= t ? 2'b10 : 2'b01;
    @(posedge pclk);
    fall_req <= 2'b00;
    repeat (6) @(posedge pclk);
  endtask

  task automatic edge_run(input logic t, input logic [1:0] m, input logic [15:0] c, input int k);
    logic [16:0] e;
    logic        ovf;
    e = {1'b0, c};
    ovf = 1'b0;
    arm(t, {2'b01, m}, c);
    for (int i = 0; i < k; i++)
    begin
      pulse(t);
      e = step(m, e[15:0]);
      ovf |= e[16];
    end
    apb(1'b0, t ? 8'h10 : 8'h0C, 32'h0000);
    check("count", rdv, {16'h0000, e[15:0]});
    check("ovf", 32'(t ? timer_b_overflow : timer_a_overflow), 32'(ovf));
    apb(1'b1, 8'h14, t ? 32'h0008 : 32'h0002);
    check("ovf ack", 32'(t ? timer_b_overflow : timer_a_overflow), 32'h0000);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fall_req = 2'b00;
    irq_lvl = 2'b11;
    cyc = 0;
    mismatches = 0;
    cmp_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    void'($urandom(50));
    check("outputs", 32'({timer_a_overflow, timer_b_overflow, ext_irq_a_flag,
      ext_irq_b_flag, aux_out}), 32'h0000);
    for (int a = 0; a <= 16; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0000);
      check("reset value", rdv, 32'h0000);
    end
    for (int i = 0; i < 4; i++)
    begin
      v1 = 32'(8'($urandom));
      apb(1'b1, 8'h08, v1);
      apb(1'b0, 8'h08, 32'h0000);
      check("aux", rdv, v1 & 32'h00FC);
      check("aux pins", 32'(aux_out), 32'(v1[5:2]));
      apb(1'b1, 8'h00, 32'(v1[7:0] ^ 8'h5A));
      apb(1'b0, 8'h00, 32'h0000);
      check("mode", rdv, 32'(v1[7:0] ^ 8'h5A));
    end
    apb(1'b1, 8'h04, 32'h00A5);
    apb(1'b0, 8'h04, 32'h0000);
    check("ctrl", rdv, 32'h00A5);
    check("ovf pins", 32'({timer_b_overflow, timer_a_overflow}), 32'h0003);
    apb(1'b1, 8'h04, 32'h0000);
    for (int i = 0; i < 6; i++)
      edge_run(i[0], i[2:1], 16'hFFFF, 2);
    edge_run(1'b0, 2'h0, 16'hFF1E, 3);
    for (int i = 0; i < 10; i++)
      edge_run(1'($urandom), 2'($urandom_range(2, 0)), 16'($urandom), $urandom_range(3, 1));
    arm(1'b0, 4'hD, 16'h0010);
    irq_lvl <= 2'b10;
    pulse(1'b0);
    apb(1'b0, 8'h0C, 32'h0000);
    check("gated", rdv, 32'h0010);
    irq_lvl <= 2'b11;
    pulse(1'b0);
    apb(1'b0, 8'h0C, 32'h0000);
    check("gate open", rdv, 32'h0011);
    apb(1'b1, 8'h04, 32'h0000);
    pulse(1'b0);
    apb(1'b0, 8'h0C, 32'h0000);
    check("stopped", rdv, 32'h0011);
    apb(1'b1, 8'h08, 32'h0080);
    apb(1'b1, 8'h0C, 32'hFF33);
    apb(1'b1, 8'h10, 32'h1234);
    apb(1'b1, 8'h00, 32'h0037);
    apb(1'b1, 8'h04, 32'h0050);
    n = 0;
    while (timer_b_overflow !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    check("split ovf", 32'({timer_b_overflow, timer_a_overflow}), 32'h0002);
    apb(1'b0, 8'h0C, 32'h0000);
    check("split low", 32'(rdv[7:0]), 32'h0033);
    apb(1'b0, 8'h10, 32'h0000);
    check("b held", rdv, 32'h1234);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 8'h08, k[0] ? 32'h00C0 : 32'h0000);
      arm(k[1], 4'h1, 16'h0000);
      apb(1'b0, k[1] ? 8'h10 : 8'h0C, 32'h0000);
      v1 = rdv;
      n = smp_cyc;
      while (cyc != n + 118)
        @(posedge pclk);
      apb(1'b0, k[1] ? 8'h10 : 8'h0C, 32'h0000);
      check("ticks", rdv - v1, k[0] ? 32'd120 : 32'd10);
    end
    apb(1'b1, 8'h04, 32'h0000);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, 8'h04, i ? 32'h0004 : 32'h0001);
      irq_lvl <= i ? 2'b01 : 2'b10;
      repeat (4) @(posedge pclk);
      irq_lvl <= 2'b11;
      repeat (4) @(posedge pclk);
      check("edge flag", 32'(i ? ext_irq_b_flag : ext_irq_a_flag), 32'h0001);
      apb(1'b1, 8'h14, i ? 32'h0004 : 32'h0001);
      check("edge ack", 32'(i ? ext_irq_b_flag : ext_irq_a_flag), 32'h0000);
      apb(1'b1, 8'h04, 32'h0000);
      irq_lvl <= i ? 2'b01 : 2'b10;
      repeat (4) @(posedge pclk);
      check("level flag", 32'(i ? ext_irq_b_flag : ext_irq_a_flag), 32'h0001);
      apb(1'b1, 8'h14, i ? 32'h0004 : 32'h0001);
      check("level ack", 32'(i ? ext_irq_b_flag : ext_irq_a_flag), 32'h0001);
      irq_lvl <= 2'b11;
      repeat (4) @(posedge pclk);
      check("level gone", 32'(i ? ext_irq_b_flag : ext_irq_a_flag), 32'h0000);
    end
    apb(1'b0, 8'h18, 32'h0000);
    check("unmapped", {rdv[30:0], rerr}, 32'h0001);
    complete_run();
  end

  initial
  begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    complete_run();
  end
endmodule

`default_nettype wire
